// >>> design/psc_pll_map.svh
// Register map, field positions, reset values and timing figures of the loop configuration block
`ifndef PSC_PLL_MAP_SVH
`define PSC_PLL_MAP_SVH

// Register addresses, one per register (16-bit registers, 16-bit address)
`define PSC_ADDR_FEEDBACK   16'hF000
`define PSC_ADDR_PRESCALE   16'hF001
`define PSC_ADDR_SOURCE     16'hF002
`define PSC_ADDR_RUN        16'hF003
`define PSC_ADDR_LOCK       16'hF004
`define PSC_ADDR_IRQ_STATUS 16'hF006
`define PSC_ADDR_IRQ_MASK   16'hF007

// Reset values
`define PSC_FEEDBACK_RESET  16'h0060
`define PSC_PRESCALE_RESET  2'h2
`define PSC_SOURCE_RESET    1'h0
`define PSC_RUN_RESET       1'h0
`define PSC_MASK_RESET      2'h0

// Field positions
`define PSC_RUN_BIT         0
`define PSC_SOURCE_BIT      0
`define PSC_LOCK_BIT        0
`define PSC_EV_LOCKED       0
`define PSC_EV_LOST         1

// Field codes
`define PSC_SOURCE_LOOP     1'h1

// Timing: clock period and typical lock time, both in ns
`define PSC_CLK_PERIOD_NS   20
`define PSC_LOCK_TIME_NS    3500000
`define PSC_LOCK_CYCLES     (`PSC_LOCK_TIME_NS / `PSC_CLK_PERIOD_NS)

// Cycles the loop is held in reset on a relock request
`define PSC_HOLD_CYCLES     3'h4

`endif

// >>> design/psc_pkg.sv
// Types and decode helpers shared by the loop configuration block
package psc_pkg;

	// Loop sequencing states
	typedef enum logic [1:0] {
		PSC_OFF     = 2'b00,
		PSC_HOLD    = 2'b01,
		PSC_ACQUIRE = 2'b10,
		PSC_LOCKED  = 2'b11
	} psc_state_e;

	// Prescale code to divide ratio: 0,1,2,3 -> 1,2,4,8
	function automatic logic [3:0] psc_ratio_of(input logic [1:0] code);
		psc_ratio_of = 4'h1 << code;
	endfunction

endpackage

// >>> design/psc_prescaler.sv
// Integer prescaler: divides the sampled master clock by 1, 2, 4 or 8
`timescale 1ns/10ps

module psc_prescaler (
	// Clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_reset_n,
	// Master clock level and ratio code
	input  wire logic       i_mclk,
	input  wire logic [1:0] i_code,
	// Divided output, one pulse per ratio input edges
	output logic            o_tick
);

	logic       mclk_q;   // Previous master clock level
	logic       mclk_d;
	logic [2:0] cnt_q;    // Rising edges counted so far
	logic [2:0] cnt_d;
	logic       tick_q;   // Registered divided tick
	logic       tick_d;
	logic       edge_w;   // Rising edge this cycle
	logic [2:0] last_w;   // Final count for the ratio

	////////////////////////////////////////////////////////////////////////
	// Next-state: count rising edges, wrap at ratio
	always_comb begin
		edge_w = i_mclk & ~mclk_q;
		last_w = 3'(psc_pkg::psc_ratio_of(i_code) - 4'h1);
		mclk_d = i_mclk;
		cnt_d  = cnt_q;
		tick_d = 1'b0;
		// Out-of-range count after a ratio change wraps on the next rising edge
		if (edge_w) begin
			if (cnt_q >= last_w) begin
				cnt_d  = 3'h0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 3'h1;
			end
		end
	end

	// Registers only
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			mclk_q <= 1'b0;
			cnt_q  <= 3'h0;
			tick_q <= 1'b0;
		end else begin
			mclk_q <= mclk_d;
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign o_tick = tick_q;

	////////////////////////////////////////////////////////////////////////
	// Divide by 1 passes every edge straight through
	a_ratio_one_pass: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(edge_w && i_code == 2'h0) |=> o_tick)
		else $error("prescaler dropped an edge at ratio 1");

	// Divide by 2 or more never ticks twice in a row
	a_ratio_spacing: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(o_tick && i_code != 2'h0 && $stable(i_code)) |=> !o_tick)
		else $error("prescaler ticked on consecutive cycles");

endmodule

// >>> design/psc_lock_timer.sv
// Lock acquisition timer: lock is declared after a settle time with input activity
`timescale 1ns/10ps
`include "psc_pll_map.svh"

module psc_lock_timer #(
	parameter int unsigned LOCK_CYCLES = `PSC_LOCK_CYCLES,
	parameter int unsigned CNT_W       = $clog2(LOCK_CYCLES + 1)
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_reset_n,
	// Acquire window and loop input activity
	input  wire logic i_enable,
	input  wire logic i_tick,
	// Settle time reached with input seen
	output logic      o_done
);

	logic [CNT_W-1:0] cnt_q;   // Cycles spent acquiring
	logic [CNT_W-1:0] cnt_d;
	logic             seen_q;  // Loop input has toggled
	logic             seen_d;
	logic             full_w;  // Settle time elapsed

	////////////////////////////////////////////////////////////////////////
	// Next-state: count while enabled, restart when dropped
	always_comb begin
		full_w = (cnt_q == CNT_W'(LOCK_CYCLES - 1));
		cnt_d  = cnt_q;
		seen_d = seen_q | i_tick;
		if (!i_enable) begin
			cnt_d  = '0;
			seen_d = 1'b0;
		end else if (!full_w) begin
			cnt_d = cnt_q + CNT_W'(1);
		end
	end

	// Registers only
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			cnt_q  <= '0;
			seen_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			seen_q <= seen_d;
		end
	end

	// No input clock, no lock, however long we wait
	assign o_done = i_enable & full_w & seen_q;

endmodule

// >>> design/psc_pll_config.sv
// Loop configuration registers, relock sequencer, lock status and interrupt
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`include "psc_pll_map.svh"

module psc_pll_config #(
	parameter int unsigned LOCK_CYCLES = `PSC_LOCK_CYCLES,
	parameter int unsigned DATA_W      = 16
) (
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_reset_n,
	// Register port
	input  wire logic [15:0]       i_addr,
	input  wire logic [DATA_W-1:0] i_wr_data,
	input  wire logic              i_wr_stb,
	input  wire logic              i_rd_stb,
	output logic      [DATA_W-1:0] o_rd_data,
	// Master clock level
	input  wire logic              i_mclk,
	// Controls to the analog loop
	output logic                   o_loop_reset,
	output logic                   o_loop_tick,
	output logic      [DATA_W-1:0] o_feedback_ratio,
	output logic      [1:0]        o_prescale_code,
	output logic                   o_sysclk_from_loop,
	// Status and interrupt
	output logic                   o_lock,
	output logic                   o_irq
);

	// Address match, used by every write decode
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [DATA_W-1:0]      fb_q;     // Feedback ratio setting
	logic [DATA_W-1:0]      fb_d;
	logic [1:0]             pre_q;    // Prescale ratio code
	logic [1:0]             pre_d;
	logic                   src_q;    // System clock source
	logic                   src_d;
	logic                   run_q;    // Loop run bit
	logic                   run_d;
	logic [1:0]             mask_q;   // Interrupt mask
	logic [1:0]             mask_d;
	logic [1:0]             stat_q;   // Sticky event bits
	logic [1:0]             stat_d;
	logic [DATA_W-1:0]      rd_q;     // Read data, one cycle late
	logic [DATA_W-1:0]      rd_d;
	psc_pkg::psc_state_e    state_q;  // Loop sequencer
	psc_pkg::psc_state_e    state_d;
	logic [2:0]             hold_q;   // Hold-reset cycles left
	logic [2:0]             hold_d;
	logic                   wr_run_w; // Run register written
	logic                   relock_w; // Run bit written as one
	logic                   tick_w;   // Prescaled loop input
	logic                   done_w;   // Lock timer finished
	logic                   locked_w; // Lock flag
	logic [1:0]             ev_w;     // Events this cycle

	////////////////////////////////////////////////////////////////////////
	// Prescaler in front of the loop
	psc_prescaler u_prescaler (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_mclk    (i_mclk),
		.i_code    (pre_q),
		.o_tick    (tick_w)
	);

	// Settle timer, runs only while acquiring
	psc_lock_timer #(
		.LOCK_CYCLES (LOCK_CYCLES)
	) u_lock_timer (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_enable  (state_q == psc_pkg::PSC_ACQUIRE),
		.i_tick    (tick_w),
		.o_done    (done_w)
	);

	////////////////////////////////////////////////////////////////////////
	// Next-state: configuration registers
	always_comb begin
		fb_d     = fb_q;
		pre_d    = pre_q;
		src_d    = src_q;
		run_d    = run_q;
		mask_d   = mask_q;
		wr_run_w = i_wr_stb & hit(i_addr, `PSC_ADDR_RUN);
		relock_w = wr_run_w & i_wr_data[`PSC_RUN_BIT];
		if (i_wr_stb) begin
			// Any 16-bit feedback value is stored; 65..127 is the useful band
			if (hit(i_addr, `PSC_ADDR_FEEDBACK))
				fb_d = i_wr_data;
			// Changes take effect on the next relock only in the analog loop
			if (hit(i_addr, `PSC_ADDR_PRESCALE))
				pre_d = i_wr_data[1:0];
			if (hit(i_addr, `PSC_ADDR_SOURCE))
				src_d = i_wr_data[`PSC_SOURCE_BIT];
			if (wr_run_w)
				run_d = i_wr_data[`PSC_RUN_BIT];
			if (hit(i_addr, `PSC_ADDR_IRQ_MASK))
				mask_d = i_wr_data[1:0];
		end
	end

	// Registers only
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			fb_q   <= `PSC_FEEDBACK_RESET;
			pre_q  <= `PSC_PRESCALE_RESET;
			src_q  <= `PSC_SOURCE_RESET;
			run_q  <= `PSC_RUN_RESET;
			mask_q <= `PSC_MASK_RESET;
		end else begin
			fb_q   <= fb_d;
			pre_q  <= pre_d;
			src_q  <= src_d;
			run_q  <= run_d;
			mask_q <= mask_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state: loop sequencer
	always_comb begin
		state_d = state_q;
		hold_d  = hold_q;
		case (state_q)
			// Loop stopped, lock flag low
			psc_pkg::PSC_OFF: begin
				if (relock_w) begin
					state_d = psc_pkg::PSC_HOLD;
					hold_d  = `PSC_HOLD_CYCLES;
				end
			end
			// Loop held in reset for a fixed count
			psc_pkg::PSC_HOLD: begin
				hold_d = hold_q - 3'h1;
				if (hold_q == 3'h1)
					state_d = psc_pkg::PSC_ACQUIRE;
			end
			// Waiting for the loop to settle
			psc_pkg::PSC_ACQUIRE: begin
				if (done_w)
					state_d = psc_pkg::PSC_LOCKED;
			end
			// Locked, stable output
			psc_pkg::PSC_LOCKED: begin
				state_d = state_q;
			end
			default: begin
				state_d = psc_pkg::PSC_OFF;
			end
		endcase
		// Relock from any state restarts the hold; clearing run stops
		if (relock_w) begin
			state_d = psc_pkg::PSC_HOLD;
			hold_d  = `PSC_HOLD_CYCLES;
		end else if (wr_run_w) begin
			state_d = psc_pkg::PSC_OFF;
			hold_d  = 3'h0;
		end
	end

	// Registers only
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			state_q <= psc_pkg::PSC_OFF;
			hold_q  <= 3'h0;
		end else begin
			state_q <= state_d;
			hold_q  <= hold_d;
		end
	end

	// Lock flag is pure state, so it drops the cycle a relock begins
	assign locked_w = (state_q == psc_pkg::PSC_LOCKED);

	////////////////////////////////////////////////////////////////////////
	// Next-state: interrupt status, read data
	always_comb begin
		ev_w = 2'h0;
		ev_w[`PSC_EV_LOCKED] = (state_q == psc_pkg::PSC_ACQUIRE) & done_w & ~wr_run_w;
		ev_w[`PSC_EV_LOST]   = locked_w & wr_run_w;
		stat_d = stat_q;
		// Write-one-to-clear; a same-cycle event wins over the clear
		if (i_wr_stb && hit(i_addr, `PSC_ADDR_IRQ_STATUS))
			stat_d = stat_q & ~i_wr_data[1:0];
		stat_d = stat_d | ev_w;
		rd_d = '0;
		// Unmapped or no read: zero
		if (i_rd_stb) begin
			case (i_addr)
				`PSC_ADDR_FEEDBACK:   rd_d = fb_q;
				`PSC_ADDR_PRESCALE:   rd_d = DATA_W'(pre_q);
				`PSC_ADDR_SOURCE:     rd_d = DATA_W'(src_q);
				`PSC_ADDR_RUN:        rd_d = DATA_W'(run_q);
				`PSC_ADDR_LOCK:       rd_d[`PSC_LOCK_BIT] = locked_w;
				`PSC_ADDR_IRQ_STATUS: rd_d = DATA_W'(stat_q);
				`PSC_ADDR_IRQ_MASK:   rd_d = DATA_W'(mask_q);
				default:              rd_d = '0;
			endcase
		end
	end

	// Registers only
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			stat_q <= 2'h0;
			rd_q   <= '0;
		end else begin
			stat_q <= stat_d;
			rd_q   <= rd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_rd_data          = rd_q;
	assign o_loop_reset       = (state_q != psc_pkg::PSC_ACQUIRE) & ~locked_w;
	assign o_loop_tick        = tick_w;
	assign o_feedback_ratio   = fb_q;
	assign o_prescale_code    = pre_q;
	assign o_sysclk_from_loop = (src_q == `PSC_SOURCE_LOOP);
	assign o_lock             = locked_w;
	assign o_irq              = |(stat_q & mask_q);

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_fb_reset_val: assert property (@(posedge i_clock)
		(i_reset_n && $past(!i_reset_n)) |-> o_feedback_ratio == `PSC_FEEDBACK_RESET)
		else $error("feedback ratio not 96 after reset");

	a_fb_write_take: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(i_wr_stb && i_addr == `PSC_ADDR_FEEDBACK) |=> o_feedback_ratio == $past(i_wr_data))
		else $error("feedback write not stored");

	a_prescale_four: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(i_wr_stb && i_addr == `PSC_ADDR_PRESCALE && i_wr_data[1:0] == 2'h2)
		|=> psc_pkg::psc_ratio_of(o_prescale_code) == 4'h4)
		else $error("prescale code 2 did not give divide by 4");

	a_source_loop: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(i_wr_stb && i_addr == `PSC_ADDR_SOURCE && i_wr_data[0]) |=> o_sysclk_from_loop)
		else $error("source 1 did not select loop output");

	a_relock_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(i_wr_stb && i_addr == `PSC_ADDR_RUN && i_wr_data[0])
		|=> (o_loop_reset && !o_lock) [*4] ##1 !o_loop_reset)
		else $error("relock did not hold loop reset four cycles");

	a_lock_after_done: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		$rose(o_lock) |-> $past(done_w) && $past(state_q) == psc_pkg::PSC_ACQUIRE)
		else $error("lock raised without settle time");

	a_lock_read_back: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(i_rd_stb && i_addr == `PSC_ADDR_LOCK) |=> o_rd_data == DATA_W'($past(o_lock)))
		else $error("lock status read wrong");

	a_lock_clear_relock: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(o_lock && i_wr_stb && i_addr == `PSC_ADDR_RUN) |=> (o_loop_reset && !o_lock))
		else $error("lock flag high while loop in reset");

	// Lock stands until the run register is written again
	a_lock_stands: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(o_lock && !(i_wr_stb && i_addr == `PSC_ADDR_RUN)) |=> o_lock)
		else $error("lock flag dropped without a run write");

	// Clearing the run bit stops the loop and holds it in reset
	a_stop_holds: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(i_wr_stb && i_addr == `PSC_ADDR_RUN && !i_wr_data[`PSC_RUN_BIT]) |=> (o_loop_reset && !o_lock))
		else $error("run clear did not stop the loop");

	// Losing lock to a run write is recorded
	a_lost_event: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(o_lock && i_wr_stb && i_addr == `PSC_ADDR_RUN) |=> stat_q[`PSC_EV_LOST])
		else $error("lock loss not recorded in status");

	// An event wins over a clear in the same cycle
	a_set_over_clear: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(ev_w != 2'h0) |=> ((stat_q & $past(ev_w)) == $past(ev_w)))
		else $error("status event lost to a same-cycle clear");

	a_irq_gate: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(stat_q[`PSC_EV_LOCKED] && mask_q[`PSC_EV_LOCKED]) |-> o_irq)
		else $error("unmasked status bit without interrupt");

endmodule

// >>> design/psc_pkg_dummy_guard.sv
// Spare compilation unit; holds no logic and no declarations
`timescale 1ns/10ps

// >>> test/psc_mclk_model.sv
// Master clock source model driving the loop configuration block
`timescale 1ns/10ps

module psc_mclk_model #(
	parameter int HALF = 2 // Half period in system cycles
) (
	// Clock and run control
	input  wire logic i_clock,
	input  wire logic i_run,
	// Master clock level
	output logic      o_mclk
);
	int cnt = 0; // Cycles into the current half period

	initial o_mclk = 1'b0;

	// Square wave only while running; stands low when stopped so no stray edge reaches the prescaler
	always @(posedge i_clock) begin
		if (!i_run) begin
			o_mclk <= 1'b0;
			cnt    <= 0;
		end else if (cnt == HALF - 1) begin
			o_mclk <= ~o_mclk;
			cnt    <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// >>> test/tb_pll_sysclk_config.sv
// Self-checking bench for the loop configuration block
`timescale 1ns/10ps

module tb_pll_sysclk_config;
	localparam int LC = 20; // Short settle count keeps the run brief

	logic        clk = 1'b0;   // System clock
	logic        rst_n = 1'b0; // Active low reset
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic        wstb = 1'b0;
	logic        rstb = 1'b0;
	logic [15:0] rdata;
	logic        mclk;         // From the source model
	logic        mrun = 1'b0;  // Source model running
	logic        loop_reset;
	logic        tick;
	logic [15:0] fb;
	logic [1:0]  pcode;
	logic        src;
	logic        lock;
	logic        irq;
	int          num_errors = 0;
	int          num_checks = 0;

	always #10 clk = ~clk;

	psc_pll_config #(.LOCK_CYCLES(LC)) u_dut (
		.i_clock(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wr_data(wdata),
		.i_wr_stb(wstb), .i_rd_stb(rstb), .o_rd_data(rdata), .i_mclk(mclk),
		.o_loop_reset(loop_reset), .o_loop_tick(tick), .o_feedback_ratio(fb),
		.o_prescale_code(pcode), .o_sysclk_from_loop(src), .o_lock(lock), .o_irq(irq)
	);

	psc_mclk_model #(.HALF(2)) u_src (.i_clock(clk), .i_run(mrun), .o_mclk(mclk));

	////////////////////////////////////////////////////////////////////////
	// Shared tasks

	// Value compare, four-state exact
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One-cycle write; returns just after the edge that took it
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wstb  <= 1'b1;
		@(posedge clk);
		wstb <= 1'b0;
		#1;
	endtask

	// One-cycle read; data looked at only in the following cycle
	task automatic rd(input logic [15:0] a, input logic [15:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rstb <= 1'b1;
		@(posedge clk);
		rstb <= 1'b0;
		#1;
		chk(nm, e, rdata);
	endtask

	// Cycles until a prescaler tick, bounded
	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (tick !== 1'b1 && n < 200);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios

	// Power-on values and an unmapped read
	task automatic t_reset;
		chk("loop reset", 16'h0001, loop_reset);
		chk("lock out", 16'h0000, lock);
		chk("irq out", 16'h0000, irq);
		rd(16'hF000, 16'h0060, "feedback");
		rd(16'hF001, 16'h0002, "prescale");
		rd(16'hF002, 16'h0000, "source");
		rd(16'hF003, 16'h0000, "run");
		rd(16'hF004, 16'h0000, "lock reg");
		rd(16'hF005, 16'h0000, "unmapped");
		$display("t_reset done");
	endtask

	// Feedback range ends, every prescale code, source select
	task automatic t_config;
		wr(16'hF000, 16'h0041);
		chk("feedback out", 16'h0041, fb);
		wr(16'hF000, 16'h007F);
		wr(16'hF005, 16'hFFFF); // Unmapped write must land nowhere
		rd(16'hF000, 16'h007F, "feedback rb");
		for (int c = 0; c < 4; c++) begin
			wr(16'hF001, 16'(c));
			chk("prescale out", 16'(c), pcode);
			rd(16'hF001, 16'(c), "prescale rb");
		end
		wr(16'hF002, 16'h0001);
		chk("source out", 16'h0001, src);
		rd(16'hF002, 16'h0001, "source rb");
		$display("t_config done");
	endtask

	// Tick spacing is ratio times the master period of 4 cycles
	task automatic t_ratio;
		int n;
		for (int c = 0; c < 4; c++) begin
			wr(16'hF001, 16'(c));
			wait_tick(n);
			wait_tick(n);
			wait_tick(n);
			chk("tick spacing", 16'(4 << c), 16'(n));
		end
		$display("t_ratio done");
	endtask

	// Run write: hold, acquire, lock, event and interrupt
	task automatic t_lock;
		int n;
		// Source runs at 12.5 MHz: divide by 4 lands near the nominal loop input
		wr(16'hF001, 16'h0002);
		// Feedback 94 gives 293.75 MHz, the highest not above the limit
		wr(16'hF000, 16'h005E);
		wr(16'hF007, 16'h0003);
		wr(16'hF003, 16'h0001);
		chk("lock on run", 16'h0000, lock);
		n = 0;
		while (loop_reset === 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("hold cycles", 16'h0004, 16'(n));
		n = 0;
		while (lock !== 1'b1 && n < 500) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("lock time", 16'(LC), 16'(n));
		rd(16'hF004, 16'h0001, "lock reg");
		rd(16'hF006, 16'h0001, "status");
		chk("irq on lock", 16'h0001, irq);
		wr(16'hF000, 16'h005D);
		chk("lock kept", 16'h0001, lock);
		wr(16'hF006, 16'h0001);
		chk("irq cleared", 16'h0000, irq);
		$display("t_lock done");
	endtask

	// Relock drops lock; masked event; no master clock gives no lock
	task automatic t_relock;
		wr(16'hF007, 16'h0000);
		wr(16'hF003, 16'h0001);
		chk("lock dropped", 16'h0000, lock);
		chk("irq masked", 16'h0000, irq);
		rd(16'hF006, 16'h0002, "lost event");
		wr(16'hF007, 16'h0002);
		chk("irq unmasked", 16'h0001, irq);
		wr(16'hF006, 16'h0002);
		chk("irq w1c", 16'h0000, irq);
		@(posedge clk);
		mrun <= 1'b0;
		repeat (8) @(posedge clk);
		wr(16'hF003, 16'h0001);
		repeat (3 * LC) @(posedge clk);
		#1;
		chk("no input no lock", 16'h0000, lock);
		wr(16'hF003, 16'h0000);
		chk("stopped reset", 16'h0001, loop_reset);
		rd(16'hF003, 16'h0000, "run rb");
		$display("t_relock done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Closing and sequencing

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Watchdog: well past the expected few hundred cycles
	initial begin
		#(20 * 20000);
		num_errors++;
		stop_test;
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		mrun  <= 1'b1; // Master clock present until t_relock stops it
		@(posedge clk);
		#1;
		t_reset;
		t_config;
		t_ratio;
		t_lock;
		t_relock;
		stop_test;
	end
endmodule
